/* File: dv/meter_settings_register_bank_test.sv */
// Self-checking bench of the meter settings register bank.
// Assumes the master model and the checker are compiled before this file.
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end

module meter_settings_register_bank_test;
  localparam int MSC = 4;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] relay_on_cmd = 2'h0;
  logic [1:0] relay_off_cmd = 2'h0;
  logic [1:0] alarm_trip = 2'h0;
  logic req_valid, rsp_valid, energy_clear_pulse, meter_hours_clear_pulse, load_hours_clear_pulse;
  logic [7:0] req_func, rsp_exception;
  logic [15:0] req_addr, req_wdata, rsp_rdata, station_address, line_speed, backlight_level;
  logic [1:0] relay_drive, parity_select, relay_alarm_above;
  logic [3:0] relay_alarm_source;
  int errors = 0;
  int compares = 0;

  always #12.5 sys_clk = ~sys_clk;

  msrb_register_bank #(.MS_CYCLES(MSC)) dut (.sys_clk, .reset, .req_valid, .req_func, .req_addr,
    .req_wdata, .rsp_valid, .rsp_rdata, .rsp_exception, .relay_on_cmd, .relay_off_cmd, .alarm_trip,
    .relay_drive, .station_address, .line_speed, .parity_select, .backlight_level, .relay_alarm_source,
    .relay_alarm_above, .energy_clear_pulse, .meter_hours_clear_pulse, .load_hours_clear_pulse);
  msrb_master_model mm (.sys_clk, .req_valid, .req_func, .req_addr, .req_wdata, .rsp_valid,
    .rsp_rdata, .rsp_exception);

  // ****************************************
  // Helpers
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [7:0] e);
    logic [15:0] r;
    logic [7:0] x;
    mm.xfer(8'h10, a, d, r, x);
    `CHK("preset answer", {e, (e == 8'h00) ? d : 16'h0000}, {x, r})
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] r;
    logic [7:0] x;
    mm.xfer(8'h03, a, 16'h0000, r, x);
    `CHK("read answer", {8'h00, d}, {x, r})
  endtask : rd

  task automatic pulse(input int r, input logic on, input logic off);
    relay_on_cmd[r] = on;
    relay_off_cmd[r] = off;
    cyc(1);
    relay_on_cmd = 2'h0;
    relay_off_cmd = 2'h0;
    cyc(1);
  endtask : pulse

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    logic [15:0] rv [37] = '{16'h0000, 16'h0001, 16'h4b00, 16'h0003, 16'h0014, 16'h0064, 16'h0001,
      16'h03e8, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0064, 16'h0002, 16'h03e8, 16'h0000, 16'h0000, 16'h0005, 16'h0000,
      16'h0000, 16'h0002, 16'h03e8, 16'h0000, 16'h0000, 16'h0005, 16'h0000, 16'h0000, 16'h0005,
      16'h0000, 16'h0000, 16'h0000};
    for (int i = 0; i < 37; i++) begin
      rd(16'h0100 + 16'(i), rv[i]);
    end
    `CHK("station port", 16'h0001, station_address)
    `CHK("backlight port", 16'h0005, backlight_level)
  endtask : t_reset

  task automatic t_speed();
    logic [15:0] sp [6] = '{16'h04b0, 16'h0960, 16'h12c0, 16'h2580, 16'h4b00, 16'h9600};
    for (int i = 0; i < 6; i++) begin
      wr(16'h0102, sp[i], 8'h00);
      `CHK("line speed port", sp[i], line_speed)
    end
    wr(16'h0102, 16'h04b1, 8'h03);
    wr(16'h0102, 16'he100, 8'h03);
    rd(16'h0102, 16'h9600);
  endtask : t_speed

  task automatic t_codes();
    logic [15:0] fa [9] = '{16'h0103, 16'h0109, 16'h010e, 16'h0113, 16'h011a, 16'h0115, 16'h011c,
      16'h0116, 16'h011d};
    int mx [9] = '{3, 2, 2, 2, 2, 3, 3, 1, 1};
    for (int i = 0; i < 9; i++) begin
      for (int v = 0; v <= mx[i]; v++) begin
        wr(fa[i], 16'(v), 8'h00);
        rd(fa[i], 16'(v));
      end
      wr(fa[i], 16'(mx[i] + 1), 8'h03);
      rd(fa[i], 16'(mx[i]));
    end
    `CHK("parity port", 2'h3, parity_select)
    `CHK("alarm source port", 4'hf, relay_alarm_source)
    `CHK("compare port", 2'h3, relay_alarm_above)
  endtask : t_codes

  task automatic t_refuse();
    logic [15:0] r;
    logic [7:0] x;
    mm.xfer(8'h04, 16'h0101, 16'h0000, r, x);
    `CHK("unknown function", 8'h01, x)
    mm.xfer(8'h03, 16'h0125, 16'h0000, r, x);
    `CHK("address above map", 8'h02, x)
    mm.xfer(8'h03, 16'h00ff, 16'h0000, r, x);
    `CHK("address below map", 8'h02, x)
    wr(16'h0101, 16'h00f8, 8'h03);
    wr(16'h0118, 16'h42c8, 8'h00);
    wr(16'h0120, 16'hffff, 8'h00);
    rd(16'h0118, 16'h42c8);
    rd(16'h0120, 16'hffff);
    rd(16'h0101, 16'h0001);
  endtask : t_refuse

  task automatic t_clear();
    logic [15:0] r;
    logic [7:0] x;
    logic [2:0] p;
    for (int i = 0; i < 3; i++) begin
      mm.xfer(8'h10, 16'h0122 + 16'(i), 16'h000a, r, x);
      p = {energy_clear_pulse, meter_hours_clear_pulse, load_hours_clear_pulse};
      `CHK("clear pulses", {8'h00, 3'b100 >> i}, {x, p})
      mm.xfer(8'h10, 16'h0122 + 16'(i), 16'h000b, r, x);
      p = {energy_clear_pulse, meter_hours_clear_pulse, load_hours_clear_pulse};
      `CHK("no clear pulse", 11'h000, {x, p})
      rd(16'h0122 + 16'(i), 16'h0000);
    end
  endtask : t_clear

  task automatic t_relay();
    int n;
    for (int r = 0; r < 2; r++) begin
      wr(r ? 16'h011a : 16'h0113, 16'h0000, 8'h00);
      pulse(r, 1'b1, 1'b1);
      `CHK("latch on wins", 1'b1, relay_drive[r])
      pulse(r, 1'b0, 1'b1);
      `CHK("latch off", 1'b0, relay_drive[r])
      wr(r ? 16'h011a : 16'h0113, 16'h0002, 8'h00);
      alarm_trip[r] = 1'b1;
      pulse(r, 1'b0, 1'b1);
      `CHK("alarm follows trip", 1'b1, relay_drive[r])
      alarm_trip[r] = 1'b0;
      cyc(2);
      `CHK("alarm released", 1'b0, relay_drive[r])
    end
    wr(16'h0113, 16'h0001, 8'h00);
    wr(16'h0114, 16'h012c, 8'h00);
    relay_on_cmd[0] = 1'b1;
    cyc(1);
    relay_on_cmd = 2'h0;
    n = 0;
    while (relay_drive[0] === 1'b1 && n < 2000) begin
      cyc(1);
      n++;
    end
    `CHK("momentary length", 1'b1, n >= 299 * MSC && n <= 300 * MSC + 3)
  endtask : t_relay

  // Reset in mid-run while a trip is pending must still give the defaults
  task automatic t_rereset();
    wr(16'h0103, 16'h0000, 8'h00);
    alarm_trip = 2'h2;
    reset = 1'b1;
    cyc(2);
    `CHK("reset outputs", {2'h3, 2'h0}, {parity_select, relay_drive})
    alarm_trip = 2'h0;
    reset = 1'b0;
    rd(16'h0102, 16'h4b00);
  endtask : t_rereset

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  initial begin
    cyc(8);
    reset = 1'b0;
    t_reset();
    t_speed();
    t_codes();
    t_refuse();
    t_clear();
    t_relay();
    t_rereset();
    print_verdict();
  end

  // Whole run needs well under 5000 cycles
  initial begin
    #(25 * 20000);
    errors++;
    print_verdict();
  end
endmodule : meter_settings_register_bank_test

bind msrb_register_bank msrb_register_bank_sva chk (.sys_clk, .reset, .req_valid, .req_func, .req_addr,
  .req_wdata, .rsp_valid, .rsp_rdata, .rsp_exception, .relay_on_cmd, .alarm_trip, .relay_drive,
  .line_speed, .parity_select, .energy_clear_pulse, .meter_hours_clear_pulse);

/* File: dv/msrb_master_model.sv */
// Modbus master model issuing one-word 03H reads and 10H presets.
// Assumes the bank answers within four cycles of the taking edge.
`timescale 1ns/1ps

module msrb_master_model (
  input wire logic sys_clk,
  output logic req_valid,
  output logic [7:0] req_func,
  output logic [15:0] req_addr,
  output logic [15:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata,
  input wire logic [7:0] rsp_exception
);
  initial begin
    req_valid = 1'b0;
    req_func = 8'h00;
    req_addr = 16'h0000;
    req_wdata = 16'h0000;
  end

  // ****************************************
  // One word per call
  // ****************************************
  // Idle lines carry inverted data so stale values never pass
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] rd, output logic [7:0] ex);
    int n;
    @(posedge sys_clk);
    #1;
    req_valid = 1'b1;
    req_func = f;
    req_addr = a;
    req_wdata = d;
    @(posedge sys_clk);
    #1;
    req_valid = 1'b0;
    req_func = ~f;
    req_addr = ~a;
    req_wdata = ~d;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 4) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    rd = rsp_rdata;
    ex = (rsp_valid === 1'b1) ? rsp_exception : 8'hee;
  endtask : xfer
endmodule : msrb_master_model

/* File: dv/msrb_register_bank_sva.sv */
// Port checks of the meter settings register bank.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps

module msrb_register_bank_sva (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata,
  input wire logic [7:0] rsp_exception,
  input wire logic [1:0] relay_on_cmd,
  input wire logic [1:0] alarm_trip,
  input wire logic [1:0] relay_drive,
  input wire logic [15:0] line_speed,
  input wire logic [1:0] parity_select,
  input wire logic energy_clear_pulse,
  input wire logic meter_hours_clear_pulse
);
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // ****************************************
  // Register port
  // ****************************************
  answer_follows_a: assert property (req_valid |=> rsp_valid)
    else $error("answer missing");
  no_stray_a: assert property (!req_valid |=> !rsp_valid)
    else $error("answer without request");
  bad_func_a: assert property (req_valid && req_func != 8'h03 && req_func != 8'h10
    |=> rsp_exception == 8'h01 && rsp_rdata == 16'h0000) else $error("function not refused");
  bad_addr_a: assert property (req_valid && (req_func == 8'h03 || req_func == 8'h10)
    && (req_addr < 16'h0100 || req_addr > 16'h0124) |=> rsp_exception == 8'h02) else $error("address not refused");
  float_word_a: assert property (req_valid && req_func == 8'h10 && req_addr == 16'h0118
    |=> rsp_exception == 8'h00 && rsp_rdata == $past(req_wdata)) else $error("threshold word refused");
  speed_legal_a: assert property (line_speed inside {16'h04b0, 16'h0960, 16'h12c0, 16'h2580,
    16'h4b00, 16'h9600}) else $error("illegal line speed");
  parity_cause_a: assert property ($changed(parity_select)
    |-> $past(req_valid && req_func == 8'h10 && req_addr == 16'h0103)) else $error("parity changed alone");

  // ****************************************
  // Clear pulses and relay
  // ****************************************
  energy_clear_a: assert property (req_valid && req_func == 8'h10 && req_addr == 16'h0122
    && req_wdata == 16'h000a |=> energy_clear_pulse ##1 (!energy_clear_pulse || $past(req_valid
    && req_func == 8'h10 && req_addr == 16'h0122 && req_wdata == 16'h000a))) else $error("energy clear wrong");
  hours_cause_a: assert property (meter_hours_clear_pulse |-> $past(req_valid)
    && $past(req_addr) == 16'h0123 && $past(req_wdata) == 16'h000a) else $error("stray hours clear");
  relay_cause_a: assert property ($rose(relay_drive[0]) |-> $past(relay_on_cmd[0] | alarm_trip[0])
    || $past(relay_on_cmd[0] | alarm_trip[0], 2)) else $error("relay rose alone");

  cover property (energy_clear_pulse);
  cover property (rsp_valid && rsp_exception == 8'h03);
  cover property ($fell(relay_drive[0]));
endmodule : msrb_register_bank_sva

/* File: verilog/msrb_pkg.sv */
// Types shared by the meter settings register bank.
// Assumes msrb_regs.svh is on the include path.
`include "msrb_regs.svh"

package msrb_pkg;

  // ****************************************
  // Field encodings
  // ****************************************
  typedef enum logic [1:0] {
    MSRB_PAR_EVEN = 2'b00,
    MSRB_PAR_ODD = 2'b01,
    MSRB_PAR_NONE_TWO = 2'b10,
    MSRB_PAR_NONE_ONE = 2'b11
  } msrb_parity_type;

  typedef enum logic [1:0] {
    MSRB_SRC_VOLTAGE = 2'b00,
    MSRB_SRC_CURRENT = 2'b01,
    MSRB_SRC_POWER = 2'b10
  } msrb_aout_source_type;

  typedef enum logic [1:0] {
    MSRB_RELAY_LATCH = 2'b00,
    MSRB_RELAY_MOMENTARY = 2'b01,
    MSRB_RELAY_ALARM = 2'b10
  } msrb_relay_mode_type;

  typedef enum logic [1:0] {
    MSRB_ALARM_NONE = 2'b00,
    MSRB_ALARM_VOLTAGE = 2'b01,
    MSRB_ALARM_CURRENT = 2'b10,
    MSRB_ALARM_POWER = 2'b11
  } msrb_alarm_source_type;

  typedef logic [15:0] msrb_word_type;

endpackage : msrb_pkg

/* File: verilog/msrb_register_bank.sv */
// Meter settings register bank: one Modbus register word per request, relay output control.
// Assumes an upstream frame handler that splits each 03H read and 10H preset into
// single-word requests on sys_clk and sends back the answer with the exception code.
//
// What this block does
// - Function 03H reads current register contents.
// - Function 10H preset stores written values.
// - Words are 16-bit unsigned, thresholds 32-bit float.
// - Line speed: six legal rates, default 19200.
// - Parity even 0, odd 1, none 2/3.
// - Analog source voltage 0, current 1, power 2.
// - Relay mode latch 0, momentary 1, alarm 2.
// - Alarm source none, voltage, current, power.
// - Alarm compare below 0, above 1.
// - Clear commands act only on enable code.
`timescale 1ns/1ps
`include "msrb_regs.svh"

module msrb_register_bank #(
  parameter int MS_CYCLES = `MSRB_MS_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  output logic [7:0] rsp_exception,
  input wire logic [1:0] relay_on_cmd,
  input wire logic [1:0] relay_off_cmd,
  input wire logic [1:0] alarm_trip,
  output logic [1:0] relay_drive,
  output logic [15:0] station_address,
  output logic [15:0] line_speed,
  output logic [1:0] parity_select,
  output logic [15:0] backlight_level,
  output logic [3:0] relay_alarm_source,
  output logic [1:0] relay_alarm_above,
  output logic energy_clear_pulse,
  output logic meter_hours_clear_pulse,
  output logic load_hours_clear_pulse
);

  localparam int WORDS = 37;
  localparam int MS_W = 16;
  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic in_map(input logic [15:0] addr);
    in_map = (addr >= `MSRB_ADDR_FIRST) && (addr <= `MSRB_ADDR_LAST);
  endfunction : in_map

  function automatic logic [5:0] word_index(input logic [15:0] addr);
    logic [15:0] diff;
    diff = addr - `MSRB_ADDR_FIRST;
    word_index = diff[5:0];
  endfunction : word_index

  function automatic logic is_clear_cmd(input logic [15:0] addr);
    is_clear_cmd = (addr == `MSRB_ENERGY_CLEAR_CMD) || (addr == `MSRB_METER_HOURS_CLEAR_CMD) ||
                   (addr == `MSRB_LOAD_HOURS_CLEAR_CMD);
  endfunction : is_clear_cmd

  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  // Out-of-range values are refused, not clipped, so the master sees its mistake
  function automatic logic value_ok(input logic [15:0] addr, input logic [15:0] v);
    case (addr)
      `MSRB_ACCESS_PASSCODE: value_ok = v <= `MSRB_PASSCODE_MAX;
      `MSRB_STATION_ADDRESS: value_ok = in_range(v, 16'h0001, `MSRB_STATION_MAX);
      `MSRB_LINE_SPEED: value_ok = (v == 16'h04b0) || (v == 16'h0960) || (v == 16'h12c0) ||
                                   (v == 16'h2580) || (v == 16'h4b00) || (v == 16'h9600);
      `MSRB_PARITY_SELECT: value_ok = v <= 16'h0003;
      `MSRB_CURRENT_FULL_SCALE: value_ok = in_range(v, `MSRB_CURRENT_FS_MIN, `MSRB_CURRENT_FS_MAX);
      `MSRB_SHUNT_FULL_SCALE: value_ok = in_range(v, `MSRB_SHUNT_MIN, `MSRB_SHUNT_MAX);
      `MSRB_CURRENT_SENSOR_RANGE,
      `MSRB_VOLTAGE_SENSOR_RANGE: value_ok = v <= 16'h0001;
      `MSRB_VOLTAGE_FULL_SCALE: value_ok = in_range(v, `MSRB_VOLTAGE_FS_MIN, `MSRB_VOLTAGE_FS_MAX);
      `MSRB_AOUT_ONE_SOURCE,
      `MSRB_AOUT_TWO_SOURCE: value_ok = v <= 16'h0002;
      `MSRB_AOUT_ONE_LOW_SIGN,
      `MSRB_AOUT_ONE_HIGH_SIGN,
      `MSRB_AOUT_TWO_LOW_SIGN,
      `MSRB_AOUT_TWO_HIGH_SIGN: value_ok = v <= 16'h0002;
      `MSRB_AOUT_ONE_LOW_PCT,
      `MSRB_AOUT_ONE_HIGH_PCT,
      `MSRB_AOUT_TWO_LOW_PCT,
      `MSRB_AOUT_TWO_HIGH_PCT: value_ok = v <= `MSRB_PCT_MAX;
      `MSRB_RELAY_ONE_MODE,
      `MSRB_RELAY_TWO_MODE: value_ok = v <= 16'h0002;
      `MSRB_RELAY_ONE_PULSE_MS,
      `MSRB_RELAY_TWO_PULSE_MS: value_ok = in_range(v, `MSRB_PULSE_MIN, `MSRB_PULSE_MAX);
      `MSRB_RELAY_ONE_ALARM_SOURCE,
      `MSRB_RELAY_TWO_ALARM_SOURCE: value_ok = v <= 16'h0003;
      `MSRB_RELAY_ONE_ALARM_COMPARE,
      `MSRB_RELAY_TWO_ALARM_COMPARE: value_ok = v <= 16'h0001;
      `MSRB_RELAY_ONE_ALARM_DELAY_S,
      `MSRB_RELAY_TWO_ALARM_DELAY_S: value_ok = v <= `MSRB_ALARM_DELAY_MAX;
      `MSRB_BACKLIGHT_LEVEL: value_ok = in_range(v, 16'h0001, `MSRB_BACKLIGHT_MAX);
      default: value_ok = 1'b1;
    endcase
  endfunction : value_ok

  function automatic logic [15:0] reset_value(input int idx);
    logic [15:0] a;
    a = 16'(idx) + `MSRB_ADDR_FIRST;
    case (a)
      `MSRB_STATION_ADDRESS: reset_value = `MSRB_RST_STATION;
      `MSRB_LINE_SPEED: reset_value = `MSRB_RST_LINE_SPEED;
      `MSRB_PARITY_SELECT: reset_value = `MSRB_RST_PARITY;
      `MSRB_CURRENT_FULL_SCALE: reset_value = `MSRB_RST_CURRENT_FS;
      `MSRB_SHUNT_FULL_SCALE: reset_value = `MSRB_RST_SHUNT_FS;
      `MSRB_CURRENT_SENSOR_RANGE,
      `MSRB_VOLTAGE_SENSOR_RANGE: reset_value = `MSRB_RST_SENSOR_RANGE;
      `MSRB_VOLTAGE_FULL_SCALE: reset_value = `MSRB_RST_VOLTAGE_FS;
      `MSRB_AOUT_ONE_HIGH_PCT,
      `MSRB_AOUT_TWO_HIGH_PCT: reset_value = `MSRB_RST_HIGH_PCT;
      `MSRB_RELAY_ONE_MODE,
      `MSRB_RELAY_TWO_MODE: reset_value = `MSRB_RST_RELAY_MODE;
      `MSRB_RELAY_ONE_PULSE_MS,
      `MSRB_RELAY_TWO_PULSE_MS: reset_value = `MSRB_RST_PULSE_MS;
      `MSRB_RELAY_ONE_ALARM_DELAY_S,
      `MSRB_RELAY_TWO_ALARM_DELAY_S: reset_value = `MSRB_RST_ALARM_DELAY;
      `MSRB_BACKLIGHT_LEVEL: reset_value = `MSRB_RST_BACKLIGHT;
      default: reset_value = `MSRB_RST_ZERO; // Sources, compare, signs, thresholds, passcode
    endcase
  endfunction : reset_value

  // ****************************************
  // Request decode
  // ****************************************
  msrb_pkg::msrb_word_type word_reg [WORDS];
  logic [7:0] exc_next;
  logic do_write;
  logic [5:0] idx;

  assign idx = word_index(req_addr);

  always_comb begin
    exc_next = `MSRB_EXC_NONE;
    do_write = 1'b0;
    if (req_func != `MSRB_FUNC_READ && req_func != `MSRB_FUNC_PRESET) begin
      exc_next = `MSRB_EXC_FUNC;
    end else if (!in_map(req_addr)) begin
      exc_next = `MSRB_EXC_ADDR;
    end else if (req_func == `MSRB_FUNC_PRESET) begin
      if (value_ok(req_addr, req_wdata)) begin
        do_write = !is_clear_cmd(req_addr);
      end else begin
        exc_next = `MSRB_EXC_VALUE;
      end
    end
  end

  // ****************************************
  // Storage
  // ****************************************
  // Threshold halves are stored as plain words; the float is only meaningful as a pair
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < WORDS; i++) begin
        word_reg[i] <= reset_value(i);
      end
    end else if (req_valid && do_write) begin
      word_reg[idx] <= req_wdata;
    end
  end

  // ****************************************
  // Answer
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
      rsp_exception <= `MSRB_EXC_NONE;
    end else begin
      rsp_valid <= req_valid;
      rsp_exception <= req_valid ? exc_next : `MSRB_EXC_NONE;
      if (req_valid && exc_next == `MSRB_EXC_NONE && req_func == `MSRB_FUNC_READ) begin
        // Write-only clear words read back as zero
        rsp_rdata <= is_clear_cmd(req_addr) ? 16'h0000 : word_reg[idx];
      end else if (req_valid && exc_next == `MSRB_EXC_NONE) begin
        rsp_rdata <= req_wdata;
      end else begin
        rsp_rdata <= 16'h0000;
      end
    end
  end

  // ****************************************
  // Clear commands
  // ****************************************
  logic clear_hit;
  assign clear_hit = req_valid && req_func == `MSRB_FUNC_PRESET && req_wdata == `MSRB_CLEAR_ENABLE;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      energy_clear_pulse <= 1'b0;
      meter_hours_clear_pulse <= 1'b0;
      load_hours_clear_pulse <= 1'b0;
    end else begin
      energy_clear_pulse <= clear_hit && req_addr == `MSRB_ENERGY_CLEAR_CMD;
      meter_hours_clear_pulse <= clear_hit && req_addr == `MSRB_METER_HOURS_CLEAR_CMD;
      load_hours_clear_pulse <= clear_hit && req_addr == `MSRB_LOAD_HOURS_CLEAR_CMD;
    end
  end

  // ****************************************
  // Configuration outputs
  // ****************************************
  localparam logic [5:0] IX_STATION = 6'h01;
  localparam logic [5:0] IX_SPEED = 6'h02;
  localparam logic [5:0] IX_PARITY = 6'h03;
  localparam logic [5:0] IX_BACKLIGHT = 6'h21;
  localparam logic [5:0] IX_MODE [2] = '{6'h13, 6'h1a};
  localparam logic [5:0] IX_PULSE [2] = '{6'h14, 6'h1b};
  localparam logic [5:0] IX_SOURCE [2] = '{6'h15, 6'h1c};
  localparam logic [5:0] IX_COMPARE [2] = '{6'h16, 6'h1d};

  assign station_address = word_reg[IX_STATION];
  assign line_speed = word_reg[IX_SPEED];
  assign parity_select = word_reg[IX_PARITY][1:0];
  assign backlight_level = word_reg[IX_BACKLIGHT];

  always_comb begin
    for (int r = 0; r < 2; r++) begin
      relay_alarm_source[2*r +: 2] = word_reg[IX_SOURCE[r]][1:0];
      relay_alarm_above[r] = word_reg[IX_COMPARE[r]][0];
    end
  end

  // ****************************************
  // Millisecond tick
  // ****************************************
  logic [15:0] ms_count_reg;
  logic ms_tick_reg;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ms_count_reg <= 16'h0000;
      ms_tick_reg <= 1'b0;
    end else begin
      ms_tick_reg <= ms_count_reg == MS_LAST;
      ms_count_reg <= (ms_count_reg == MS_LAST) ? 16'h0000 : ms_count_reg + 16'h0001;
    end
  end

  // ****************************************
  // Relay outputs
  // ****************************************
  logic [MS_W-1:0] pulse_left_reg [2];

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      relay_drive <= 2'b00;
      for (int r = 0; r < 2; r++) begin
        pulse_left_reg[r] <= 16'h0000;
      end
    end else begin
      for (int r = 0; r < 2; r++) begin
        unique case (msrb_pkg::msrb_relay_mode_type'(word_reg[IX_MODE[r]][1:0]))
          msrb_pkg::MSRB_RELAY_LATCH: begin
            pulse_left_reg[r] <= 16'h0000;
            if (relay_on_cmd[r]) begin
              relay_drive[r] <= 1'b1;
            end else if (relay_off_cmd[r]) begin
              relay_drive[r] <= 1'b0;
            end
          end
          msrb_pkg::MSRB_RELAY_MOMENTARY: begin
            // Pulse length is sampled at the command; a later change waits for the next pulse
            if (relay_on_cmd[r]) begin
              relay_drive[r] <= 1'b1;
              pulse_left_reg[r] <= word_reg[IX_PULSE[r]];
            end else if (relay_drive[r] && ms_tick_reg) begin
              pulse_left_reg[r] <= pulse_left_reg[r] - 16'h0001;
              if (pulse_left_reg[r] <= 16'h0001) begin
                relay_drive[r] <= 1'b0;
              end
            end
          end
          msrb_pkg::MSRB_RELAY_ALARM: begin
            pulse_left_reg[r] <= 16'h0000;
            relay_drive[r] <= alarm_trip[r];
          end
          default: begin
            // Code 3 cannot be stored; hold the relay released if it ever appears
            pulse_left_reg[r] <= 16'h0000;
            relay_drive[r] <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : msrb_register_bank

/* File: verilog/msrb_regs.svh */
// Constants of the meter settings register bank: addresses, reset values, limits, timing.
// Assumes inclusion by bare name from the package and the design file.
`ifndef MSRB_REGS_SVH
`define MSRB_REGS_SVH

// ****************************************
// Function codes and exception codes
// ****************************************
`define MSRB_FUNC_READ 8'h03
`define MSRB_FUNC_PRESET 8'h10
`define MSRB_EXC_NONE 8'h00
`define MSRB_EXC_FUNC 8'h01
`define MSRB_EXC_ADDR 8'h02
`define MSRB_EXC_VALUE 8'h03

// ****************************************
// Register addresses
// ****************************************
`define MSRB_ADDR_FIRST 16'h0100
`define MSRB_ADDR_LAST 16'h0124
`define MSRB_ACCESS_PASSCODE 16'h0100
`define MSRB_STATION_ADDRESS 16'h0101
`define MSRB_LINE_SPEED 16'h0102
`define MSRB_PARITY_SELECT 16'h0103
`define MSRB_CURRENT_FULL_SCALE 16'h0104
`define MSRB_SHUNT_FULL_SCALE 16'h0105
`define MSRB_CURRENT_SENSOR_RANGE 16'h0106
`define MSRB_VOLTAGE_FULL_SCALE 16'h0107
`define MSRB_VOLTAGE_SENSOR_RANGE 16'h0108
`define MSRB_AOUT_ONE_SOURCE 16'h0109
`define MSRB_AOUT_ONE_LOW_SIGN 16'h010a
`define MSRB_AOUT_ONE_LOW_PCT 16'h010b
`define MSRB_AOUT_ONE_HIGH_SIGN 16'h010c
`define MSRB_AOUT_ONE_HIGH_PCT 16'h010d
`define MSRB_AOUT_TWO_SOURCE 16'h010e
`define MSRB_AOUT_TWO_LOW_SIGN 16'h010f
`define MSRB_AOUT_TWO_LOW_PCT 16'h0110
`define MSRB_AOUT_TWO_HIGH_SIGN 16'h0111
`define MSRB_AOUT_TWO_HIGH_PCT 16'h0112
`define MSRB_RELAY_ONE_MODE 16'h0113
`define MSRB_RELAY_ONE_PULSE_MS 16'h0114
`define MSRB_RELAY_ONE_ALARM_SOURCE 16'h0115
`define MSRB_RELAY_ONE_ALARM_COMPARE 16'h0116
`define MSRB_RELAY_ONE_ALARM_DELAY_S 16'h0117
`define MSRB_RELAY_ONE_ALARM_LEVEL 16'h0118
`define MSRB_RELAY_TWO_MODE 16'h011a
`define MSRB_RELAY_TWO_PULSE_MS 16'h011b
`define MSRB_RELAY_TWO_ALARM_SOURCE 16'h011c
`define MSRB_RELAY_TWO_ALARM_COMPARE 16'h011d
`define MSRB_RELAY_TWO_ALARM_DELAY_S 16'h011e
`define MSRB_RELAY_TWO_ALARM_LEVEL 16'h011f
`define MSRB_BACKLIGHT_LEVEL 16'h0121
`define MSRB_ENERGY_CLEAR_CMD 16'h0122
`define MSRB_METER_HOURS_CLEAR_CMD 16'h0123
`define MSRB_LOAD_HOURS_CLEAR_CMD 16'h0124
`define MSRB_CLEAR_ENABLE 16'h000a

// ****************************************
// Reset values
// ****************************************
`define MSRB_RST_PASSCODE 16'h0000
`define MSRB_RST_STATION 16'h0001
`define MSRB_RST_LINE_SPEED 16'h4b00
`define MSRB_RST_PARITY 16'h0003
`define MSRB_RST_CURRENT_FS 16'h0014
`define MSRB_RST_SHUNT_FS 16'h0064
`define MSRB_RST_SENSOR_RANGE 16'h0001
`define MSRB_RST_VOLTAGE_FS 16'h03e8
`define MSRB_RST_HIGH_PCT 16'h0064
`define MSRB_RST_RELAY_MODE 16'h0002
`define MSRB_RST_PULSE_MS 16'h03e8
`define MSRB_RST_ALARM_DELAY 16'h0005
`define MSRB_RST_BACKLIGHT 16'h0005
`define MSRB_RST_ZERO 16'h0000

// ****************************************
// Value limits
// ****************************************
`define MSRB_PASSCODE_MAX 16'h270f
`define MSRB_STATION_MAX 16'h00f7
`define MSRB_CURRENT_FS_MIN 16'h0014
`define MSRB_CURRENT_FS_MAX 16'hc350
`define MSRB_SHUNT_MIN 16'h0032
`define MSRB_SHUNT_MAX 16'h0064
`define MSRB_VOLTAGE_FS_MIN 16'h0005
`define MSRB_VOLTAGE_FS_MAX 16'h270f
`define MSRB_PCT_MAX 16'h0064
`define MSRB_PULSE_MIN 16'h012c
`define MSRB_PULSE_MAX 16'h1388
`define MSRB_ALARM_DELAY_MAX 16'h00ff
`define MSRB_BACKLIGHT_MAX 16'h0005

// ****************************************
// Timing
// ****************************************
`define MSRB_CLK_HZ 40000000
`define MSRB_MS_PER_S 1000
`define MSRB_MS_CYCLES (`MSRB_CLK_HZ / `MSRB_MS_PER_S)

`endif
